// *** asp_pkg.sv ***
package asp_pkg;

    // Register field layout of converter_control.
    localparam int CTRL_CHAN_LSB = 0;
    localparam int CTRL_CHAN_W = 3;
    localparam int CTRL_BUSY_BIT = 3;
    localparam int CTRL_DONE_BIT = 4;

    // Reset values.
    localparam logic [2:0] CHAN_RESET = 3'h0;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [7:0] BUF_DIS_RESET = 8'h00;

    // Timing, counted in machine cycles of the core clock.
    localparam int CLKS_PER_MCYCLE = 12;
    localparam int CONV_MCYCLES = 40;
    localparam int MCOUNT_W = 6;
    localparam logic [MCOUNT_W-1:0] MCOUNT_LAST = MCOUNT_W'(CONV_MCYCLES - 1);

    typedef enum logic [0:0] {
        ASP_ST_IDLE = 1'b0,
        ASP_ST_CONVERT = 1'b1
    } asp_state_t;

    typedef struct packed {
        asp_state_t state;
        logic done;
        logic busy;
        logic [CTRL_CHAN_W-1:0] chan;
        logic [7:0] buf_dis;
        logic [7:0] result;
        logic [MCOUNT_W-1:0] mcount;
        logic conv_start;
        logic [7:0] pin_read;
    } asp_regs_t;

endpackage

// *** asp_sync.sv ***
`timescale 1ns/1ns
`default_nettype none

module asp_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // asp_sync

`default_nettype wire

// *** asp_mcycle_tick.sv ***
`timescale 1ns/1ns
`default_nettype none

module asp_mcycle_tick #(
    parameter int CLKS = 12
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clr,
    output logic tick
);
    localparam int CW = $clog2(CLKS);
    localparam logic [CW-1:0] LAST = CW'(CLKS - 1);

    logic [CW-1:0] cnt;

    // The count restarts on clr so a conversion spans whole machine cycles.
    assign tick = (cnt == LAST);

    always_ff @(posedge clk) begin
        if (!rst_b || clr) begin
            cnt <= '0;
        end else if (tick) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + CW'(1);
        end
    end
endmodule // asp_mcycle_tick

`default_nettype wire

// *** asp_converter_ctrl.sv ***
// What this block does
// (RULE_01) Conversion lasts exactly forty machine cycles.
// (RULE_02) One of eight inputs to 8-bit converter.
// (RULE_03) Three-bit field, bit 2 MSB, picks channel.
// (RULE_04) Channel writable only when done and busy low.
// (RULE_05) Completion sets done flag, loads result.
// (RULE_06) Start during conversion leaves it untouched.
// (RULE_07) Result held while done flag stays set.
// (RULE_08) Starts while busy or done are discarded.
// (RULE_09) Idle or power-down aborts running conversion.
// (RULE_10) Done result survives idle, lost on power-down.
// (RULE_11) Writing busy bit starts; reads high throughout.
// (RULE_12) Port pins readable at any time.
// (RULE_13) Selected channel pin reads 1, others true.
// (RULE_14) After reset all pins are digital inputs.
// (RULE_15) Buffer disables change only at conversion start.
// (RULE_16) Disabled pins read 1 until start corrects.
// (RULE_17) Software picks channel and starts in one write.
// (RULE_18) Digital-only use never writes control register.
// (RULE_19) Busy clears as done sets; software cannot clear.
// (RULE_20) Interrupt requested while done and enable set.
// (RULE_21) Software clears done flag before next start.
// (RULE_22) Result read-only; counter steps per machine cycle.
`timescale 1ns/1ns
`default_nettype none

module asp_converter_ctrl
    import asp_pkg::*;
#(
    parameter int CLKS_PER_MC = CLKS_PER_MCYCLE
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ctrl_wr,
    input wire logic [7:0] ctrl_wdata,
    output logic [7:0] ctrl_rdata,
    input wire logic result_wr,
    output logic [7:0] result_rdata,
    input wire logic idle_request,
    input wire logic powerdown_request,
    input wire logic converter_irq_enable,
    output logic converter_irq,
    input wire logic [7:0] analog_input_pins,
    output logic [7:0] port1_read_data,
    output logic [7:0] digital_buffer_disable,
    output logic [CTRL_CHAN_W-1:0] conv_mux_sel,
    output logic conv_start,
    output logic conv_active,
    input wire logic [7:0] conv_code
);
    asp_regs_t r;
    asp_regs_t next_r;
    logic [7:0] pins_sync;
    logic launch;
    logic tick;
    logic unused_result_wr;

    // Port pins arrive from outside the clock domain.
    asp_sync #(
        .WIDTH(8)
    ) u_pin_sync (
        .clk(clk),
        .rst_b(rst_b),
        .async_in(analog_input_pins),
        .sync_out(pins_sync)
    );

    asp_mcycle_tick #(
        .CLKS(CLKS_PER_MC)
    ) u_tick (
        .clk(clk),
        .rst_b(rst_b),
        .clr(launch),
        .tick(tick)
    );

    // A start is taken only with busy and done both low and no power mode pending.
    assign launch = ctrl_wr && ctrl_wdata[CTRL_BUSY_BIT] && !r.busy && !r.done
                    && !idle_request && !powerdown_request; // RULE_06 RULE_08 RULE_11

    // The result register has no write path; writes are dropped.
    assign unused_result_wr = result_wr; // RULE_22

    always_comb begin
        next_r = r;
        next_r.conv_start = 1'b0;
        next_r.pin_read = pins_sync | r.buf_dis; // RULE_12 RULE_13 RULE_16
        if (ctrl_wr && !ctrl_wdata[CTRL_DONE_BIT]) begin
            next_r.done = 1'b0;
        end
        if (ctrl_wr && !r.busy && !r.done) begin
            next_r.chan = ctrl_wdata[CTRL_CHAN_LSB +: CTRL_CHAN_W]; // RULE_03 RULE_04
        end
        if (powerdown_request) begin
            next_r.state = ASP_ST_IDLE; // RULE_09
            next_r.busy = 1'b0;
            next_r.done = 1'b0; // RULE_10
            next_r.result = RESULT_RESET; // RULE_10
        end else if (idle_request) begin
            // A finished result is kept; only a running conversion is dropped.
            next_r.state = ASP_ST_IDLE; // RULE_09 RULE_10
            next_r.busy = 1'b0;
        end else begin
            case (r.state)
                ASP_ST_IDLE: begin
                    if (launch) begin
                        next_r.state = ASP_ST_CONVERT; // RULE_11
                        next_r.busy = 1'b1;
                        next_r.mcount = '0;
                        next_r.conv_start = 1'b1;
                        next_r.buf_dis = 8'h01 << ctrl_wdata[CTRL_CHAN_LSB +: CTRL_CHAN_W]; // RULE_15
                    end
                end
                ASP_ST_CONVERT: begin
                    if (tick) begin
                        if (r.mcount == MCOUNT_LAST) begin
                            // Setting the flag overrides a clear written this cycle.
                            next_r.state = ASP_ST_IDLE; // RULE_01
                            next_r.busy = 1'b0; // RULE_19
                            next_r.done = 1'b1; // RULE_05 RULE_19
                            next_r.result = conv_code; // RULE_02 RULE_05
                        end else begin
                            next_r.mcount = r.mcount + MCOUNT_W'(1); // RULE_22
                        end
                    end
                end
                default: begin
                    next_r.state = ASP_ST_IDLE;
                    next_r.busy = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            r.state <= ASP_ST_IDLE;
            r.done <= 1'b0;
            r.busy <= 1'b0;
            r.chan <= CHAN_RESET;
            r.buf_dis <= BUF_DIS_RESET; // RULE_14
            r.result <= RESULT_RESET;
            r.mcount <= '0;
            r.conv_start <= 1'b0;
            r.pin_read <= 8'hff;
        end else begin
            r <= next_r;
        end
    end

    assign ctrl_rdata = {3'h0, r.done, r.busy, r.chan};
    assign result_rdata = r.result; // RULE_07
    assign converter_irq = r.done && converter_irq_enable; // RULE_20
    assign port1_read_data = r.pin_read;
    assign digital_buffer_disable = r.buf_dis;
    assign conv_mux_sel = r.chan; // RULE_02
    assign conv_start = r.conv_start;
    assign conv_active = r.busy;
endmodule // asp_converter_ctrl

`default_nettype wire

// *** asp_ctrl_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
module asp_ctrl_asserts
    import asp_pkg::*;
#(parameter int CLKS_PER_MC = CLKS_PER_MCYCLE) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] ctrl_rdata,
    input wire logic [7:0] result_rdata,
    input wire logic idle_request,
    input wire logic powerdown_request,
    input wire logic converter_irq_enable,
    input wire logic converter_irq,
    input wire logic [7:0] port1_read_data,
    input wire logic [7:0] digital_buffer_disable,
    input wire logic [CTRL_CHAN_W-1:0] conv_mux_sel,
    input wire logic conv_start,
    input wire logic conv_active
);
    int act_cnt;
    always_ff @(posedge clk) begin
        act_cnt <= conv_active ? act_cnt + 1 : 0;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence done_rise;
        $rose(ctrl_rdata[CTRL_DONE_BIT]);
    endsequence
    a_conv_length: assert property (done_rise |-> act_cnt == CONV_MCYCLES * CLKS_PER_MC)
        else $error("conversion length wrong");
    a_busy_done_swap: assert property (done_rise |-> $fell(ctrl_rdata[CTRL_BUSY_BIT]))
        else $error("busy not cleared with done");
    a_result_held: assert property (ctrl_rdata[CTRL_DONE_BIT] |=>
        !ctrl_rdata[CTRL_DONE_BIT] || $stable(result_rdata)) else $error("result moved");
    a_irq_follows: assert property (converter_irq == (ctrl_rdata[CTRL_DONE_BIT] && converter_irq_enable))
        else $error("irq wrong");
    a_sel_pin_one: assert property (conv_active && $past(conv_active) |->
        port1_read_data[conv_mux_sel]) else $error("selected pin not 1");
    a_buf_one_hot: assert property (conv_start |-> digital_buffer_disable == 8'h01 << conv_mux_sel)
        else $error("buffer mask wrong");
    a_buf_at_start: assert property ($changed(digital_buffer_disable) |-> conv_start)
        else $error("buffer mask moved");
    a_mode_abort: assert property (idle_request || powerdown_request |=> !conv_active)
        else $error("no abort");
endmodule // asp_ctrl_asserts
bind asp_converter_ctrl asp_ctrl_asserts #(.CLKS_PER_MC(CLKS_PER_MC)) asp_ctrl_asserts_inst (.*);
`default_nettype wire

// *** asp_conv_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module asp_conv_model
    import asp_pkg::*;
(
    input wire logic clk,
    input wire logic conv_active,
    input wire logic [CTRL_CHAN_W-1:0] conv_mux_sel,
    output logic [7:0] conv_code
);
    // Code names the channel so a wrong mux shows; idle output toggles as nothing is valid.
    always_ff @(posedge clk) begin
        conv_code <= conv_active ? {5'h15, conv_mux_sel} : ~conv_code;
    end
endmodule // asp_conv_model
`default_nettype wire

// *** asp_converter_ctrl_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module asp_converter_ctrl_tb
    import asp_pkg::*;
;
    localparam int P = 2;
    logic clk = 1'b0, rst_b = 1'b0, ctrl_wr = 1'b0, result_wr = 1'b0, irq_en = 1'b0;
    logic idle_request = 1'b0, powerdown_request = 1'b0, irq, active, start;
    logic [7:0] wdata = 8'h00, pins = 8'h5a, ctrl, res, port1, bufd, code;
    logic [2:0] sel;
    int error_cnt = 0, checks_done = 0, n;
    asp_converter_ctrl #(.CLKS_PER_MC(P)) asp_converter_ctrl_inst (.clk(clk), .rst_b(rst_b),
        .ctrl_wr(ctrl_wr), .ctrl_wdata(wdata), .ctrl_rdata(ctrl), .result_wr(result_wr),
        .result_rdata(res), .idle_request(idle_request), .powerdown_request(powerdown_request),
        .converter_irq_enable(irq_en), .converter_irq(irq), .analog_input_pins(pins),
        .port1_read_data(port1), .digital_buffer_disable(bufd), .conv_mux_sel(sel),
        .conv_start(start), .conv_active(active), .conv_code(code));
    asp_conv_model asp_conv_model_inst (.clk(clk), .conv_active(active), .conv_mux_sel(sel),
        .conv_code(code));
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // One strobe per call; the trailing delay keeps checks clear of the edge.
    task automatic wr(input logic [7:0] d, input logic r, input logic i, input logic p);
        @(posedge clk);
        ctrl_wr <= !r && !i && !p;
        result_wr <= r;
        idle_request <= i;
        powerdown_request <= p;
        wdata <= d;
        @(posedge clk);
        {ctrl_wr, result_wr, idle_request, powerdown_request} <= 4'h0;
        #1;
    endtask
    task automatic wait_done();
        n = 0;
        while (ctrl[CTRL_DONE_BIT] !== 1'b1 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        forever #5 clk = ~clk;
    end
    initial begin
        #100000;
        error_cnt++;
        end_sim();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("ctrl", ctrl, 8'h00);
        chk("port", port1, pins);
        for (int ch = 0; ch < 8; ch++) begin
            @(posedge clk) irq_en <= 1'(ch % 2);
            wr(8'h08 | 8'(ch), 0, 0, 0);
            chk("busy", ctrl, 8'h08 | 8'(ch));
            wr(8'h08 | 8'(7 - ch), 0, 0, 0);
            wait_done();
            chk("cycles", 8'(n), 8'(CONV_MCYCLES * P - 2));
            chk("done", ctrl, 8'h10 | 8'(ch));
            chk("result", res, 8'ha8 | 8'(ch));
            chk("pins", port1, pins | (8'h01 << ch));
            chk("irq", {7'h00, irq}, 8'(ch % 2));
            wr(8'h1f ^ 8'(ch), 0, 0, 0);
            wr(8'h55, 1, 0, 0);
            chk("locked", ctrl, 8'h10 | 8'(ch));
            chk("kept", res, 8'ha8 | 8'(ch));
            wr(8'h00, 0, 0, 0);
            chk("clear", ctrl, 8'(ch));
        end
        wr(8'h0b, 0, 0, 0);
        wr(8'h00, 0, 1, 0);
        chk("idle abort", ctrl, 8'h03);
        wr(8'h0b, 0, 0, 0);
        wait_done();
        wr(8'h00, 0, 1, 0);
        chk("idle keep", res, 8'hab);
        wr(8'h00, 0, 0, 1);
        chk("pd flag", ctrl, 8'h03);
        chk("pd result", res, 8'h00);
        end_sim();
    end
endmodule // asp_converter_ctrl_tb
`default_nettype wire
